// ==== sici_pkg.sv ====
/*
  Shared constants and types for the signaling and idle-code insertion block:
  register offsets, reset values, array geometry and the bit-source encoding.
  Assumes nothing of its surroundings; compiled before every other file.
*/
package sici_pkg;

  typedef logic [7:0] sici_byte_t;
  typedef logic [5:0] sici_idx_t;

  // register offsets on the byte-wide host port
  localparam logic [7:0] SICI_OFS_SIE_A = 8'h08;
  localparam logic [7:0] SICI_OFS_SIE_B = 8'h09;
  localparam logic [7:0] SICI_OFS_SIE_C = 8'h0A;
  localparam logic [7:0] SICI_OFS_SIE_D = 8'h0B;
  localparam logic [7:0] SICI_OFS_PTR = 8'h7E;
  localparam logic [7:0] SICI_OFS_CODE = 8'h7F;
  localparam logic [7:0] SICI_OFS_TX_EN = 8'h80;
  localparam logic [7:0] SICI_OFS_RX_EN = 8'h84;

  localparam sici_byte_t SICI_RST_BYTE = 8'h00;
  localparam logic [1:0] SICI_RST_PIPE = 2'h0;

  // field positions
  localparam int SICI_ALIGN_SRC_BIT = 0;
  localparam int SICI_ALL_TX_BIT = 6;
  localparam int SICI_ALL_RX_BIT = 7;

  // array geometry: transmit entries first, receive entries above
  localparam int SICI_CHANS = 32;
  localparam int SICI_T1_CHANS = 24;
  localparam int SICI_ENTRIES = 64;
  localparam sici_idx_t SICI_RX_BASE = 6'h20;
  localparam logic [2:0] SICI_LOWER_NIBBLE_IDX = 3'h4;

  // which source drives the outgoing bit
  typedef enum logic [2:0] {
    SICI_SRC_DATA = 3'h1,
    SICI_SRC_IDLE = 3'h2,
    SICI_SRC_SIG = 3'h4
  } sici_src_t;

endpackage

// ==== sici_mem_if.sv ====
/*
  Connection between the insertion control and the idle-code array:
  one write port with block-write flags and three registered read ports.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sici_mem_if;
  import sici_pkg::*;
  logic we;
  sici_idx_t waddr;
  sici_byte_t wdata;
  logic all_tx;
  logic all_rx;
  sici_idx_t cpu_raddr;
  sici_idx_t tx_raddr;
  sici_idx_t rx_raddr;
  sici_byte_t cpu_rdata;
  sici_byte_t tx_rdata;
  sici_byte_t rx_rdata;

  modport ctrl (
    output we, waddr, wdata, all_tx, all_rx, cpu_raddr, tx_raddr, rx_raddr,
    input cpu_rdata, tx_rdata, rx_rdata
  );
  modport mem (
    input we, waddr, wdata, all_tx, all_rx, cpu_raddr, tx_raddr, rx_raddr,
    output cpu_rdata, tx_rdata, rx_rdata
  );
endinterface

// ==== sici_idle_mem.sv ====
/*
  Idle-code array: 64 bytes, transmit codes at 0..31, receive codes at 32..63.
  Single or block write, three read ports whose data come from registers.
  Assumes a synchronised active-low reset and the shared clock.
*/
`timescale 1ns/1ps
module sici_idle_mem (
  input wire logic clock,
  input wire logic rst_sync_n,
  sici_mem_if.mem bus
);
  import sici_pkg::*;

  sici_byte_t code [SICI_ENTRIES];

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < SICI_ENTRIES; i++) begin
        code[i] <= SICI_RST_BYTE;
      end
    end else if (bus.we) begin
      for (int i = 0; i < SICI_ENTRIES; i++) begin
        if ((bus.all_tx && i < SICI_CHANS) ||
            (bus.all_rx && i >= SICI_CHANS) ||
            (!bus.all_tx && !bus.all_rx && bus.waddr == 6'(i))) begin // RL15 RL18
          code[i] <= bus.wdata; // RL11 RL13
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus.cpu_rdata <= SICI_RST_BYTE;
      bus.tx_rdata <= SICI_RST_BYTE;
      bus.rx_rdata <= SICI_RST_BYTE;
    end else begin
      bus.cpu_rdata <= code[bus.cpu_raddr];
      bus.tx_rdata <= code[bus.tx_raddr];
      bus.rx_rdata <= code[bus.rx_raddr];
    end
  end

endmodule

// ==== sici_top.sv ====
/*
  Per-channel signaling insertion and idle-code substitution for a T1/E1
  transmit framer, with the receive-side idle substitution beside it.
  Assumes the framer supplies bit strobes, channel and bit indices and the
  software signaling bit; all inputs are synchronous to clock.
*/
// Operation
// RL1: E1 CAS upper align nibble from first register
// RL2: E1 CAS lower align bits from first register
// RL3: E1 channel enables spread over four registers
// RL4: set bit inserts register signaling, clear does not
// RL5: T1 uses three registers, channels 1-24 flat
// RL6: hardware mode inserts signaling pin bits
// RL7: per-channel select for hardware signaling
// RL8: insertion independent of backplane clock rate
// RL9: host keeps ctrl3 bit 7 low then
// RL10: T1 ignores idle channels 25 to 32
// RL11: 64-byte idle array behind two registers
// RL12: pointer 0-31 transmit, 32-63 receive
// RL13: write pointer, then code stores entry
// RL14: pointer increments after each data access
// RL15: pointer bits 6/7 block-write codes
// RL16: host clears bits 6/7 before reading
// RL17: substitute idle code only when enabled
// RL18: decode block-write bits into four cases
// RL19: idle code lsb sent last
// RL20: enable register covers eight channels, bit0 lowest
`timescale 1ns/1ps
module sici_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire sici_pkg::sici_byte_t reg_wdata,
  output sici_pkg::sici_byte_t reg_rdata,
  input wire logic e1_mode,
  input wire logic cas_mode,
  input wire logic hw_sig_mode,
  input wire logic [31:0] hw_signaling_channel_select,
  input wire sici_pkg::sici_byte_t first_transmit_signaling_reg,
  input wire logic tx_bit_strobe,
  input wire logic [4:0] tx_chan,
  input wire logic [2:0] tx_bit_idx,
  input wire logic transmit_serial_data_in,
  input wire logic signaling_serial_in,
  input wire logic tx_sig_bit,
  input wire logic [4:0] tx_sig_chan,
  input wire logic sw_sig_bit,
  input wire logic cas_align_slot,
  output logic tx_line_out,
  input wire logic rx_bit_strobe,
  input wire logic [4:0] rx_chan,
  input wire logic [2:0] rx_bit_idx,
  input wire logic rx_data_in,
  output logic rx_data_out
);
  import sici_pkg::*;

  logic [1:0] rst_pipe;
  logic rst_sync_n;
  sici_byte_t sie [4];
  sici_byte_t tx_en [4];
  sici_byte_t rx_en [4];
  sici_byte_t ptr;
  sici_byte_t next_rdata;
  sici_src_t tx_src;
  sici_src_t next_tx_src;
  logic next_tx_bit;
  logic sig_value;
  logic upper_align_nibble_src;
  logic lower_align_nibble_src;
  logic [31:0] e1_sw_map;
  logic [31:0] t1_sw_map;
  logic [31:0] sw_map;
  logic [31:0] hw_map;
  logic [31:0] tx_idle_substitute_enables;
  logic [31:0] rx_idle_substitute_enables;
  logic code_access;
  logic all_transmit_broadcast;
  logic all_receive_broadcast;

  sici_mem_if mem_bus ();

  function automatic logic in_group(input logic [7:0] addr, input logic [7:0] base);
    return addr[7:2] == base[7:2];
  endfunction

  // msb goes out first, so the lsb lands in the last bit time
  function automatic logic code_bit(input sici_byte_t code, input logic [2:0] idx);
    return code[3'h7 - idx]; // RL19
  endfunction

  function automatic logic idle_on(input logic [31:0] en, input logic [4:0] ch,
                                   input logic e1);
    return en[ch] && (e1 || ch < 5'(SICI_T1_CHANS)); // RL10 RL17
  endfunction

  // two-stage release; only the second stage fans out
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= SICI_RST_PIPE;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 4; i++) begin
        sie[i] <= SICI_RST_BYTE;
      end
    end else if (reg_wr && in_group(reg_addr, SICI_OFS_SIE_A)) begin
      sie[reg_addr[1:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 4; i++) begin
        tx_en[i] <= SICI_RST_BYTE;
        rx_en[i] <= SICI_RST_BYTE;
      end
    end else if (reg_wr && in_group(reg_addr, SICI_OFS_TX_EN)) begin
      tx_en[reg_addr[1:0]] <= reg_wdata; // RL20
    end else if (reg_wr && in_group(reg_addr, SICI_OFS_RX_EN)) begin
      rx_en[reg_addr[1:0]] <= reg_wdata; // RL20
    end
  end

  assign code_access = (reg_wr || reg_rd) && reg_addr == SICI_OFS_CODE;

  // only the channel field counts; the broadcast bits survive the increment
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr <= SICI_RST_BYTE;
    end else if (reg_wr && reg_addr == SICI_OFS_PTR) begin
      ptr <= reg_wdata; // RL13
    end else if (code_access) begin
      ptr <= {ptr[7:6], ptr[5:0] + 6'h01}; // RL14
    end
  end

  assign all_transmit_broadcast = ptr[SICI_ALL_TX_BIT];
  assign all_receive_broadcast = ptr[SICI_ALL_RX_BIT];

  assign mem_bus.we = reg_wr && reg_addr == SICI_OFS_CODE; // RL13
  assign mem_bus.waddr = ptr[5:0];
  assign mem_bus.wdata = reg_wdata;
  assign mem_bus.all_tx = all_transmit_broadcast; // RL15
  assign mem_bus.all_rx = all_receive_broadcast; // RL15
  // reading with a broadcast bit set would still return one entry only
  assign mem_bus.cpu_raddr = ptr[5:0]; // RL16
  assign mem_bus.tx_raddr = {1'b0, tx_chan}; // RL12
  assign mem_bus.rx_raddr = SICI_RX_BASE | {1'b0, rx_chan}; // RL12

  sici_idle_mem u_mem (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .bus(mem_bus)
  );

  always_comb begin
    next_rdata = SICI_RST_BYTE;
    if (in_group(reg_addr, SICI_OFS_SIE_A)) begin
      next_rdata = sie[reg_addr[1:0]];
    end else if (in_group(reg_addr, SICI_OFS_TX_EN)) begin
      next_rdata = tx_en[reg_addr[1:0]];
    end else if (in_group(reg_addr, SICI_OFS_RX_EN)) begin
      next_rdata = rx_en[reg_addr[1:0]];
    end else if (reg_addr == SICI_OFS_PTR) begin
      next_rdata = ptr;
    end else if (reg_addr == SICI_OFS_CODE) begin
      next_rdata = mem_bus.cpu_rdata; // RL11
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= SICI_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  assign upper_align_nibble_src = sie[0][SICI_ALIGN_SRC_BIT]; // RL1
  assign lower_align_nibble_src = sie[2][SICI_ALIGN_SRC_BIT]; // RL2

  // maps indexed by phone channel number; position 0 never enabled
  assign e1_sw_map = {1'b0, sie[3], sie[2][7:1], sie[1], sie[0][7:1], 1'b0}; // RL3
  assign t1_sw_map = {7'h00, sie[2], sie[1], sie[0], 1'b0}; // RL5
  assign sw_map = e1_mode ? e1_sw_map : t1_sw_map;
  assign hw_map = {hw_signaling_channel_select[30:0], 1'b0}; // RL7

  assign tx_idle_substitute_enables = {tx_en[3], tx_en[2], tx_en[1], tx_en[0]};
  assign rx_idle_substitute_enables = {rx_en[3], rx_en[2], rx_en[1], rx_en[0]};

  // signaling overlays idle codes, which overlay backplane data
  always_comb begin
    next_tx_src = SICI_SRC_DATA;
    sig_value = 1'b0;
    if (e1_mode && cas_mode && cas_align_slot) begin
      if (tx_bit_idx < SICI_LOWER_NIBBLE_IDX) begin
        if (upper_align_nibble_src) begin
          next_tx_src = SICI_SRC_SIG;
          sig_value = code_bit(first_transmit_signaling_reg, tx_bit_idx); // RL1
        end
      end else if (lower_align_nibble_src) begin
        next_tx_src = SICI_SRC_SIG;
        sig_value = code_bit(first_transmit_signaling_reg, tx_bit_idx); // RL2
      end
    end else if (tx_sig_bit && hw_sig_mode && hw_map[tx_sig_chan]) begin
      next_tx_src = SICI_SRC_SIG;
      sig_value = signaling_serial_in; // RL6 RL7
    end else if (tx_sig_bit && sw_map[tx_sig_chan]) begin
      next_tx_src = SICI_SRC_SIG;
      sig_value = sw_sig_bit; // RL4
    end
    if (next_tx_src == SICI_SRC_DATA &&
        idle_on(tx_idle_substitute_enables, tx_chan, e1_mode)) begin
      next_tx_src = SICI_SRC_IDLE; // RL17
    end
  end

  always_comb begin
    case (next_tx_src)
      SICI_SRC_SIG: begin
        next_tx_bit = sig_value;
      end
      SICI_SRC_IDLE: begin
        next_tx_bit = code_bit(mem_bus.tx_rdata, tx_bit_idx);
      end
      default: begin
        next_tx_bit = transmit_serial_data_in;
      end
    endcase
  end

  // paced by the bit strobe alone, so any backplane rate works
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_line_out <= 1'b0;
      tx_src <= SICI_SRC_DATA;
    end else if (tx_bit_strobe) begin
      tx_line_out <= next_tx_bit; // RL8
      tx_src <= next_tx_src;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_data_out <= 1'b0;
    end else if (rx_bit_strobe) begin
      if (idle_on(rx_idle_substitute_enables, rx_chan, e1_mode)) begin
        rx_data_out <= code_bit(mem_bus.rx_rdata, rx_bit_idx); // RL17 RL19
      end else begin
        rx_data_out <= rx_data_in;
      end
    end
  end

  // checking
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_n);

  logic [5:0] ptr_idx;
  logic ts1_top;
  logic ts1_low;
  assign ptr_idx = ptr[5:0];
  assign ts1_top = first_transmit_signaling_reg[7];
  assign ts1_low = first_transmit_signaling_reg[0];

  AST_UPPER_NIBBLE: assert property ( // RL1
    tx_bit_strobe && e1_mode && cas_mode && cas_align_slot &&
    tx_bit_idx == 3'h0 && sie[0][0] |=> tx_line_out == $past(ts1_top))
    else $error("upper align nibble not taken from first register");

  AST_LOWER_NIBBLE: assert property ( // RL2
    tx_bit_strobe && e1_mode && cas_mode && cas_align_slot &&
    tx_bit_idx == 3'h7 && sie[2][0] |=> tx_line_out == $past(ts1_low))
    else $error("lower align bits not taken from first register");

  AST_E1_CH23_MAP: assert property ( // RL3
    tx_bit_strobe && e1_mode && !cas_align_slot && tx_sig_bit && !hw_sig_mode &&
    tx_sig_chan == 5'h17 && sie[3][0] |=> tx_line_out == $past(sw_sig_bit))
    else $error("channel 23 enable not mapped to fourth register bit 0");

  AST_SW_CLEAR_PASS: assert property ( // RL4
    tx_bit_strobe && !cas_align_slot && tx_sig_bit && !hw_sig_mode &&
    !sw_map[tx_sig_chan] && !tx_idle_substitute_enables[tx_chan]
    |=> tx_src == SICI_SRC_DATA && tx_line_out == $past(transmit_serial_data_in))
    else $error("signaling inserted for a disabled channel");

  AST_T1_CH24_MAP: assert property ( // RL5
    tx_bit_strobe && !e1_mode && tx_sig_bit && !hw_sig_mode &&
    tx_sig_chan == 5'h18 && sie[2][7] |=> tx_line_out == $past(sw_sig_bit))
    else $error("T1 channel 24 enable not mapped to third register bit 7");

  AST_HW_INSERT: assert property ( // RL6
    tx_bit_strobe && !cas_align_slot && tx_sig_bit && hw_sig_mode &&
    hw_map[tx_sig_chan] |=> tx_line_out == $past(signaling_serial_in))
    else $error("hardware signaling bit not inserted");

  AST_T1_IDLE_IGNORED: assert property ( // RL10
    tx_bit_strobe && !e1_mode && !tx_sig_bit && tx_chan >= 5'h18
    |=> tx_src == SICI_SRC_DATA)
    else $error("idle code substituted in T1 channel above 24");

  AST_PTR_INCR: assert property ( // RL14
    code_access |=> ptr_idx == $past(ptr_idx) + 6'h01)
    else $error("array pointer did not advance after data access");

  AST_RX_PASS: assert property ( // RL17
    rx_bit_strobe && !rx_idle_substitute_enables[rx_chan]
    |=> rx_data_out == $past(rx_data_in))
    else $error("receive data replaced without enable");

  // pointer reloaded to the written entry, so the read-back must match
  AST_WRITE_STORES: assert property ( // RL13
    reg_wr && reg_addr == SICI_OFS_CODE && ptr[7:6] == 2'h0 ##1 !reg_wr && !reg_rd
    ##1 reg_wr && reg_addr == SICI_OFS_PTR && reg_wdata == {2'h0, $past(ptr_idx, 2)}
    ##1 !reg_wr && !reg_rd ##1 reg_rd && reg_addr == SICI_OFS_CODE
    |=> reg_rdata == $past(reg_wdata, 5))
    else $error("stored idle code not read back");

  AST_TX_LSB_LAST: assert property ( // RL19
    tx_bit_strobe && !tx_sig_bit && !cas_align_slot && tx_bit_idx == 3'h7 &&
    idle_on(tx_idle_substitute_enables, tx_chan, e1_mode)
    |=> tx_src == SICI_SRC_IDLE && tx_line_out == $past(mem_bus.tx_rdata[0]))
    else $error("transmit idle code lsb not sent last");

  AST_RX_MSB_FIRST: assert property ( // RL17
    rx_bit_strobe && rx_bit_idx == 3'h0 &&
    idle_on(rx_idle_substitute_enables, rx_chan, e1_mode)
    |=> rx_data_out == $past(mem_bus.rx_rdata[7]))
    else $error("receive idle code msb not sent first");

  COV_BLOCK_WRITE: cover property (
    reg_wr && reg_addr == SICI_OFS_CODE && ptr[7:6] == 2'h3);
  COV_HW_INSERT: cover property (
    tx_bit_strobe && tx_sig_bit && hw_sig_mode && hw_map[tx_sig_chan]);
  COV_TX_IDLE: cover property (tx_bit_strobe ##1 tx_src == SICI_SRC_IDLE);
  COV_CAS_ALIGN: cover property (
    tx_bit_strobe && cas_align_slot && e1_mode && cas_mode && sie[0][0]);

endmodule

// ==== sici_pcm_src.sv ====
/*
  Backplane model: one PCM stream of bit strobes, slot and bit indices,
  a data bit and a signaling-pin bit, all driven at the falling edge.
  Assumes the bench feeds it random bits and a run/slow control.
*/
`timescale 1ns/1ps
module sici_pcm_src (
  input wire logic clock,
  input wire logic run,
  input wire logic slow,
  input wire logic [1:0] rnd,
  output logic strobe,
  output logic [4:0] chan,
  output logic [2:0] idx,
  output logic data,
  output logic sig
);
  logic [2:0] phase;
  initial begin
    phase = 3'h0;
    strobe = 1'b0;
    {chan, idx, data, sig} = 10'h000;
  end
  // slot and bit move two cycles ahead of the strobe (six when slow), so the array read settles
  always @(negedge clock) begin
    strobe <= run && phase == (slow ? 3'h5 : 3'h1);
    if (run) begin
      if (phase == (slow ? 3'h7 : 3'h3)) begin
        phase <= 3'h0;
        {chan, idx} <= {chan, idx} + 8'h01;
        data <= rnd[0];
        sig <= rnd[1];
      end else begin
        phase <= phase + 3'h1;
      end
    end
  end
endmodule

// ==== sici_top_tb.sv ====
/*
  Self-checking bench for sici_top: a bench model of the registers, the
  idle array and the per-bit source choice, compared at every result.
  Assumes the two-flop reset release and registered one-cycle answers.
*/
`timescale 1ns/1ps
module sici_top_tb;
  import sici_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  sici_byte_t reg_wdata = 8'h00;
  sici_byte_t reg_rdata;
  logic e1 = 1'b0, cas = 1'b0, hw = 1'b0, sigb = 1'b0, swb = 1'b0, casb = 1'b0;
  logic [31:0] hsel = 32'h0;
  logic [7:0] ts1 = 8'h00;
  logic [4:0] sigch = 5'h01;
  logic txs, txd, txg, rxs, rxd, txo, rxo, tx_exp, rx_exp;
  logic txp = 1'b0;
  logic rxp = 1'b0;
  logic [4:0] txc, rxc;
  logic [2:0] txi, rxi;
  logic [15:0] lf = 16'h0057;
  logic [7:0] sie [4] = '{default: 8'h00};
  logic [7:0] en [8] = '{default: 8'h00};
  logic [7:0] mem [64] = '{default: 8'h00};
  logic [7:0] ptr = 8'h00;
  int err_count = 0;
  int checks_done = 0;

  always #2.5 clock = ~clock;

  sici_top u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .e1_mode(e1),
    .cas_mode(cas), .hw_sig_mode(hw), .hw_signaling_channel_select(hsel),
    .first_transmit_signaling_reg(ts1), .tx_bit_strobe(txs), .tx_chan(txc),
    .tx_bit_idx(txi), .transmit_serial_data_in(txd), .signaling_serial_in(txg),
    .tx_sig_bit(sigb), .tx_sig_chan(sigch), .sw_sig_bit(swb), .cas_align_slot(casb),
    .tx_line_out(txo), .rx_bit_strobe(rxs), .rx_chan(rxc), .rx_bit_idx(rxi),
    .rx_data_in(rxd), .rx_data_out(rxo));
  sici_pcm_src u_txsrc (.clock(clock), .run(run), .slow(slow), .rnd(lf[1:0]),
    .strobe(txs), .chan(txc), .idx(txi), .data(txd), .sig(txg));
  sici_pcm_src u_rxsrc (.clock(clock), .run(run), .slow(slow), .rnd(lf[3:2]),
    .strobe(rxs), .chan(rxc), .idx(rxi), .data(rxd), .sig());

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // software enable per 1-based channel; upper_align_nibble_src/lower_align_nibble_src bits drop out in E1
  function automatic logic swen(input logic [4:0] ch);
    logic [31:0] v;
    v = e1 ? {2'b00, sie[3], sie[2][7:1], sie[1], sie[0][7:1]} : {8'h00, sie[2], sie[1], sie[0]};
    return v[ch - 5'h01];
  endfunction

  function automatic logic idle_or(input int base, input logic [4:0] c, input logic [2:0] i,
                                   input logic d);
    logic [31:0] v;
    v = base != 0 ? {en[7], en[6], en[5], en[4]} : {en[3], en[2], en[1], en[0]};
    if (v[c] && (e1 || c < 5'h18)) return mem[base + c][7 - i];
    return d;
  endfunction

  // cas slot and signaling bit never come together from the bench
  function automatic logic exp_tx();
    if (e1 && cas && casb && sie[txi < 3'h4 ? 0 : 2][0]) return ts1[7 - txi];
    if (sigb && hw && hsel[sigch - 5'h01]) return txg;
    if (sigb && swen(sigch)) return swb;
    return idle_or(0, txc, txi, txd);
  endfunction

  always @(negedge clock) begin
    lf <= nx(lf);
    if (run) begin
      sigb <= lf[4];
      swb <= lf[5];
      casb <= lf[6] & ~lf[4];
      sigch <= 5'((lf[12:8] % (e1 ? 30 : 24)) + 1);
    end
  end

  always @(posedge clock) begin
    txp <= run && txs;
    rxp <= run && rxs;
    tx_exp <= exp_tx();
    rx_exp <= idle_or(32, rxc, rxi, rxd);
  end

  always @(negedge clock) begin
    if (txp) check("tx_line_out", 8'(txo), 8'(tx_exp));
    if (rxp) check("rx_data_out", 8'(rxo), 8'(rx_exp));
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    if (a >= 8'h08 && a <= 8'h0B) sie[a - 8'h08] = d;
    if (a >= 8'h80 && a <= 8'h87) en[a - 8'h80] = d;
    if (a == 8'h7E) ptr = d;
    if (a == 8'h7F) begin
      for (int i = 0; i < 64; i++)
        if (i < 32 ? ptr[6] : ptr[7]) mem[i] = d;
      if (ptr[7:6] == 2'b00) mem[ptr[5:0]] = d;
      ptr[5:0] = ptr[5:0] + 6'h01;
    end
  endtask

  // leading idle cycle keeps array reads apart from the previous access
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a >= 8'h08 && a <= 8'h0B) e = sie[a - 8'h08];
    if (a >= 8'h80 && a <= 8'h87) e = en[a - 8'h80];
    if (a == 8'h7E) e = ptr;
    if (a == 8'h7F) e = mem[ptr[5:0]];
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    if (a == 8'h7F) ptr[5:0] = ptr[5:0] + 6'h01;
    check("reg_rdata", reg_rdata, e);
  endtask

  task automatic rd_all();
    for (int a = 0; a < 256; a++) rd_chk(8'(a));
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (100000) @(negedge clock);
    err_count++;
    final_report();
  end

  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    rd_all();
    $display("test reset values done");
    for (int a = 0; a < 256; a++)
      if (a != 8'h7E && a != 8'h7F) wr(8'(a), lf[7:0]);
    rd_all();
    $display("test register access done");
    wr(8'h7E, 8'h02);
    wr(8'h7F, 8'h7E);
    wr(8'h7F, 8'hEE);
    wr(8'h7E, 8'h3F);
    wr(8'h7F, 8'h5A);
    wr(8'h7E, 8'h3F);
    rd_chk(8'h7F);
    rd_chk(8'h7E);
    // block writes from widest to single so all but the whole-array one leave a visible trace
    for (int m = 3; m >= 0; m--) begin
      wr(8'h7E, {2'(m), lf[5:0]});
      wr(8'h7F, lf[15:8]);
      rd_chk(8'h7E);
    end
    wr(8'h7E, 8'h00);
    for (int i = 0; i < 64; i++) rd_chk(8'h7F);
    wr(8'h7E, 8'h00);
    for (int i = 0; i < 64; i++) wr(8'h7F, lf[7:0]);
    for (int i = 0; i < 64; i++) rd_chk(8'h7F);
    $display("test idle array done");
    for (int m = 0; m < 8; m++) begin
      e1 = m[2];
      cas = m[1];
      hw = m[0];
      slow = m[1] ^ m[0];
      ts1 = lf[7:0];
      hsel[15:0] = lf;
      @(negedge clock);
      hsel[31:16] = lf;
      for (int a = 8; a < 12; a++) wr(8'(a), lf[7:0]);
      for (int a = 128; a < 136; a++) wr(8'(a), lf[15:8]);
      run <= 1'b1;
      repeat (2200) @(negedge clock);
      run <= 1'b0;
      repeat (12) @(negedge clock);
      $display("test stream mode %0d done", m);
    end
    final_report();
  end
endmodule
